// ### rtl/counter_array_defs.svh
// constants of the counter array: register offsets, field positions, reset values, divider counts
// assumes a 32-bit Avalon-MM slave port, byte addresses, one register per aligned word
`ifndef COUNTER_ARRAY_DEFS_SVH
`define COUNTER_ARRAY_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define CA_OFF_CTRL 8'h00
`define CA_OFF_MODE 8'h04
`define CA_OFF_CNT_LO 8'h08
`define CA_OFF_CNT_HI 8'h0C
`define CA_OFF_CH_BASE 8'h10
`define CA_OFF_CH_STRIDE 8'h10
`define CA_OFF_CH_MODE 8'h00
`define CA_OFF_CH_LOW 8'h04
`define CA_OFF_CH_HIGH 8'h08

// ****************************************************************
// field positions
// ****************************************************************
`define CA_CTRL_OVF_BIT 7
`define CA_CTRL_RUN_BIT 6
`define CA_MODE_IDLE_BIT 7
`define CA_MODE_WDEN_BIT 6
`define CA_MODE_LOCK_BIT 5
`define CA_MODE_SEL_LSB 1
`define CA_MODE_SEL_MSB 3
`define CA_MODE_OVFIE_BIT 0
`define CA_CH_WIDE_BIT 7
`define CA_CH_CMPEN_BIT 6
`define CA_CH_MATCH_BIT 3
`define CA_CH_PWM_BIT 1
`define CA_CH_IRQEN_BIT 0

// ****************************************************************
// reset values and divider counts
// ****************************************************************
`define CA_RST_WDEN 1'b1
`define CA_RST_SEL 3'h0
`define CA_RST_COUNT 16'h0000
`define CA_RST_CMP 16'h0000
`define CA_RST_CH_MODE 8'h00
`define CA_DIV_MAX 4'hB
`define CA_DIV4_MASK 2'h3
`define CA_COUNT_TOP 16'hFFFF
`define CA_LOW_TOP 8'hFF

`endif

// ### rtl/counter_array_pkg.sv
// types used by the counter array design
// assumes counter_array_defs.svh supplies the numeric constants
package counter_array_pkg;

    // array clock source select codes
    typedef enum logic [2:0] {
        SRC_DIV12 = 3'h0,
        SRC_DIV4 = 3'h1,
        SRC_EXT = 3'h2,
        SRC_SYS = 3'h4
    } clk_src_t;

endpackage : counter_array_pkg

// ### rtl/counter_array_pwm16_watchdog.sv
// counter array with 16-bit pulse-width channels and a channel-based watchdog
// assumes one 50 MHz clock, synchronous active-high reset, Avalon-MM slave on the bus side
`timescale 1ns/1ps
`include "counter_array_defs.svh"

module counter_array_pwm16_watchdog #(
    parameter int CHANNELS = 3,
    parameter int WATCHDOG_CHANNEL = 2
) (
    input wire logic CLK_SYS_I, // system clock, 50 MHz
    input wire logic RESET_I, // synchronous reset, active high
    input wire logic [7:0] ADDRESS_I, // byte address
    input wire logic READ_I, // read request
    input wire logic WRITE_I, // write request
    input wire logic [31:0] WRITEDATA_I, // write data
    input wire logic [3:0] BYTEENABLE_I, // byte lanes
    output logic [31:0] READDATA_O, // read data, registered
    output logic WAITREQUEST_O, // stall, combinational
    input wire logic IDLE_I, // processor is in idle mode
    input wire logic EXT_TICK_I, // external array clock enable pulse
    output logic [CHANNELS-1:0] CHANNEL_OUTPUT_PIN_O, // channel outputs
    output logic WATCHDOG_RESET_O // system reset request pulse
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [3:0] div;
        logic [15:0] count;
        logic counter_overflow_flag;
        logic counter_run;
        logic [CHANNELS-1:0] channel_event_flag;
        logic idle_suspend;
        logic watchdog_enable;
        logic watchdog_lock;
        logic [2:0] clock_source_select;
        logic ovf_irq_enable;
        logic [CHANNELS-1:0][7:0] channel_mode_reg;
        logic [CHANNELS-1:0][15:0] channel_compare_value;
        logic [CHANNELS-1:0] pin;
        logic wd_reset;
    } state_t;

    state_t s;
    state_t next_s;

    logic watchdog_on;
    logic src_tick;
    logic tick;
    logic [15:0] count_inc;
    logic overflow;
    logic low_overflow;
    logic watchdog_hit;
    logic [CHANNELS-1:0] wide_match;

    // ****************************************************************
    // timebase
    // ****************************************************************

    // watchdog counts as on while either enable or lock is set
    assign watchdog_on = s.watchdog_enable | s.watchdog_lock;

    // clock source pick; reserved codes fall back to divide by twelve
    always_comb begin
        case (s.clock_source_select)
            counter_array_pkg::SRC_DIV12: src_tick = (s.div == `CA_DIV_MAX);
            counter_array_pkg::SRC_DIV4: src_tick = (s.div[1:0] == `CA_DIV4_MASK);
            counter_array_pkg::SRC_EXT: src_tick = EXT_TICK_I;
            counter_array_pkg::SRC_SYS: src_tick = 1'b1;
            default: src_tick = (s.div == `CA_DIV_MAX);
        endcase
    end

    // counter runs on the run bit or the watchdog, unless idle suspends it
    assign tick = (s.counter_run | watchdog_on)
        & ~(s.idle_suspend & IDLE_I) & src_tick;
    assign count_inc = s.count + 16'h0001;
    assign overflow = tick & (s.count == `CA_COUNT_TOP);
    assign low_overflow = tick & (s.count[7:0] == `CA_LOW_TOP);
    // watchdog channel high byte against counter high byte at low wrap
    assign watchdog_hit = low_overflow & watchdog_on
        & (s.channel_compare_value[WATCHDOG_CHANNEL][15:8] == s.count[15:8]);

    // ****************************************************************
    // comparators
    // ****************************************************************

    // one 16-bit comparator per channel, evaluated on the counter's next value
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : gen_cmp
            assign wide_match[g] = tick & (count_inc == s.channel_compare_value[g]);
        end
    endgenerate

    // ****************************************************************
    // read mux
    // ****************************************************************
    function automatic logic [31:0] read_word(input state_t st, input logic [7:0] addr);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (addr == `CA_OFF_CTRL) begin
            r[`CA_CTRL_OVF_BIT] = st.counter_overflow_flag;
            r[`CA_CTRL_RUN_BIT] = st.counter_run;
            r[CHANNELS-1:0] = st.channel_event_flag;
        end else if (addr == `CA_OFF_MODE) begin
            r[`CA_MODE_IDLE_BIT] = st.idle_suspend;
            r[`CA_MODE_WDEN_BIT] = st.watchdog_enable;
            r[`CA_MODE_LOCK_BIT] = st.watchdog_lock;
            r[`CA_MODE_SEL_MSB:`CA_MODE_SEL_LSB] = st.clock_source_select;
            r[`CA_MODE_OVFIE_BIT] = st.ovf_irq_enable;
        end else if (addr == `CA_OFF_CNT_LO) begin
            r[7:0] = st.count[7:0];
        end else if (addr == `CA_OFF_CNT_HI) begin
            r[7:0] = st.count[15:8];
        end
        for (int i = 0; i < CHANNELS; i++) begin
            if (addr == 8'(`CA_OFF_CH_BASE + i * `CA_OFF_CH_STRIDE + `CA_OFF_CH_MODE)) begin
                r[7:0] = st.channel_mode_reg[i];
            end
            if (addr == 8'(`CA_OFF_CH_BASE + i * `CA_OFF_CH_STRIDE + `CA_OFF_CH_LOW)) begin
                r[7:0] = st.channel_compare_value[i][7:0];
            end
            if (addr == 8'(`CA_OFF_CH_BASE + i * `CA_OFF_CH_STRIDE + `CA_OFF_CH_HIGH)) begin
                r[7:0] = st.channel_compare_value[i][15:8];
            end
        end
        return r;
    endfunction : read_word

    // ****************************************************************
    // next state
    // ****************************************************************

    // order matters: counting first, then bus writes, then hardware flag sets,
    // so a flag set by an event always beats a clear in the same cycle
    always_comb begin
        logic do_write;
        logic is_wd;
        logic wide_mode;
        logic [7:0] wd;
        logic force_reset;
        do_write = s.ack & WRITE_I & BYTEENABLE_I[0];
        wd = WRITEDATA_I[7:0];
        is_wd = 1'b0;
        wide_mode = 1'b0;
        force_reset = 1'b0;
        next_s = s;
        next_s.wd_reset = 1'b0;

        // bus handshake: one wait state, read data captured on the first cycle
        next_s.ack = (READ_I | WRITE_I) & ~s.ack;
        if (READ_I & ~s.ack) begin
            next_s.rdata = read_word(s, ADDRESS_I);
        end

        // divider runs free so the array clock phase does not depend on run state
        next_s.div = (s.div == `CA_DIV_MAX) ? 4'h0 : s.div + 4'h1;
        if (tick) begin
            next_s.count = count_inc;
        end

        // pulse-width outputs; overflow clears first so a zero compare stays high
        for (int i = 0; i < CHANNELS; i++) begin
            is_wd = watchdog_on && (i == WATCHDOG_CHANNEL);
            wide_mode = s.channel_mode_reg[i][`CA_CH_CMPEN_BIT]
                & s.channel_mode_reg[i][`CA_CH_PWM_BIT]
                & s.channel_mode_reg[i][`CA_CH_WIDE_BIT] & ~is_wd;
            if (!wide_mode) begin
                next_s.pin[i] = 1'b0;
            end else begin
                // no cycle-length field is consulted here
                if (overflow) begin
                    next_s.pin[i] = 1'b0;
                end
                if (wide_match[i]) begin
                    next_s.pin[i] = 1'b1;
                end
            end
        end

        // register writes
        if (do_write) begin
            if (ADDRESS_I == `CA_OFF_CTRL) begin
                next_s.counter_overflow_flag = wd[`CA_CTRL_OVF_BIT];
                next_s.counter_run = wd[`CA_CTRL_RUN_BIT];
                next_s.channel_event_flag = wd[CHANNELS-1:0];
                force_reset = watchdog_on & wd[WATCHDOG_CHANNEL];
            end
            if (ADDRESS_I == `CA_OFF_MODE) begin
                next_s.watchdog_lock = s.watchdog_lock | wd[`CA_MODE_LOCK_BIT];
                next_s.watchdog_enable = wd[`CA_MODE_WDEN_BIT];
                next_s.ovf_irq_enable = wd[`CA_MODE_OVFIE_BIT];
                if (!watchdog_on) begin
                    next_s.idle_suspend = wd[`CA_MODE_IDLE_BIT];
                    next_s.clock_source_select = wd[`CA_MODE_SEL_MSB:`CA_MODE_SEL_LSB];
                end
            end
            // counter writes win over the tick of the same cycle
            if (ADDRESS_I == `CA_OFF_CNT_LO && !watchdog_on) begin
                next_s.count[7:0] = wd;
            end
            if (ADDRESS_I == `CA_OFF_CNT_HI && !watchdog_on) begin
                next_s.count[15:8] = wd;
            end
            for (int i = 0; i < CHANNELS; i++) begin
                is_wd = watchdog_on && (i == WATCHDOG_CHANNEL);
                if (ADDRESS_I == 8'(`CA_OFF_CH_BASE + i * `CA_OFF_CH_STRIDE + `CA_OFF_CH_MODE)
                    && !is_wd) begin
                    next_s.channel_mode_reg[i] = wd;
                end
                if (ADDRESS_I == 8'(`CA_OFF_CH_BASE + i * `CA_OFF_CH_STRIDE + `CA_OFF_CH_LOW)) begin
                    next_s.channel_compare_value[i][7:0] = wd;
                    next_s.channel_mode_reg[i][`CA_CH_CMPEN_BIT] = is_wd;
                end
                if (ADDRESS_I == 8'(`CA_OFF_CH_BASE + i * `CA_OFF_CH_STRIDE + `CA_OFF_CH_HIGH)) begin
                    if (is_wd) begin
                        // any value reloads; the offset sits in the low byte
                        next_s.channel_compare_value[i][15:8] =
                            s.count[15:8] + s.channel_compare_value[i][7:0];
                    end else begin
                        next_s.channel_compare_value[i][15:8] = wd;
                    end
                    next_s.channel_mode_reg[i][`CA_CH_CMPEN_BIT] = 1'b1;
                end
            end
        end

        // hardware flag sets after the writes so they win
        if (overflow) begin
            next_s.counter_overflow_flag = 1'b1;
        end
        for (int i = 0; i < CHANNELS; i++) begin
            is_wd = watchdog_on && (i == WATCHDOG_CHANNEL);
            if (wide_match[i] && !is_wd
                && s.channel_mode_reg[i][`CA_CH_CMPEN_BIT]
                && s.channel_mode_reg[i][`CA_CH_MATCH_BIT]) begin
                next_s.channel_event_flag[i] = 1'b1;
            end
        end

        // single-cycle reset request to the system reset logic
        next_s.wd_reset = watchdog_hit | force_reset;
    end

    // ****************************************************************
    // registers
    // ****************************************************************

    // reset puts the watchdog on with offset zero and divide by twelve
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            s <= '0;
            s.watchdog_enable <= `CA_RST_WDEN;
            s.clock_source_select <= `CA_RST_SEL;
            s.count <= `CA_RST_COUNT;
            for (int i = 0; i < CHANNELS; i++) begin
                s.channel_mode_reg[i] <= `CA_RST_CH_MODE;
                s.channel_compare_value[i] <= `CA_RST_CMP;
            end
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************

    // waitrequest drops one cycle after the request rises
    assign WAITREQUEST_O = (READ_I | WRITE_I) & ~s.ack;
    assign READDATA_O = s.rdata;
    assign CHANNEL_OUTPUT_PIN_O = s.pin;
    assign WATCHDOG_RESET_O = s.wd_reset;

endmodule : counter_array_pwm16_watchdog

// ### tb/counter_array_assertions.sv
// checker for bus handshake, channel pins and watchdog pulse of the counter array
// assumes it is bound into the design top and sees only that module's ports
`timescale 1ns/1ps
`include "counter_array_defs.svh"
module counter_array_checker #(
    parameter int CHANNELS = 3
) (
    input wire logic CLK_SYS_I, // clock
    input wire logic RESET_I, // reset
    input wire logic [7:0] ADDRESS_I, // address
    input wire logic READ_I, // read
    input wire logic WRITE_I, // write
    input wire logic [31:0] WRITEDATA_I, // write data
    input wire logic [3:0] BYTEENABLE_I, // lanes
    input wire logic [31:0] READDATA_O, // read data
    input wire logic WAITREQUEST_O, // stall
    input wire logic [CHANNELS-1:0] CHANNEL_OUTPUT_PIN_O, // pins
    input wire logic WATCHDOG_RESET_O // reset pulse
);
    // ****************
    // watchdog shadow
    // ****************
    logic acc;
    logic wd_on;
    logic wd_lock;
    // accepted write: the cycle whose closing edge sees waitrequest low
    assign acc = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];
    // lock only clears on reset, so it keeps the shadow enabled
    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            wd_on <= 1'b1;
            wd_lock <= 1'b0;
        end else if (acc && ADDRESS_I == `CA_OFF_MODE) begin
            wd_lock <= wd_lock | WRITEDATA_I[5];
            wd_on <= wd_lock | WRITEDATA_I[5] | WRITEDATA_I[6];
        end
    end
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    wait_first_a: assert property ((READ_I || WRITE_I) && !$past(READ_I || WRITE_I) |-> WAITREQUEST_O)
        else $error("no wait state on new request");
    wait_one_a: assert property (WAITREQUEST_O |=> !WAITREQUEST_O)
        else $error("more than one wait state");
    no_req_wait_a: assert property (!(READ_I || WRITE_I) |-> !WAITREQUEST_O)
        else $error("stall without request");
    rd_upper_a: assert property (READDATA_O[31:8] == 24'h000000)
        else $error("read data upper bits set");
    pulse_one_a: assert property (WATCHDOG_RESET_O |=> !WATCHDOG_RESET_O)
        else $error("reset pulse longer than one cycle");
    force_rst_a: assert property (acc && ADDRESS_I == `CA_OFF_CTRL && WRITEDATA_I[2] && wd_on
        |-> ##[1:2] WATCHDOG_RESET_O)
        else $error("flag write did not force reset");
    quiet_off_a: assert property (!wd_on && !$past(wd_on) && !$past(wd_on, 2)
        |-> !WATCHDOG_RESET_O)
        else $error("reset pulse while watchdog off");
    wd_pin_low_a: assert property (wd_on && $past(wd_on) |-> !CHANNEL_OUTPUT_PIN_O[2])
        else $error("watchdog channel pin driven");
    low_clear_a: assert property (acc && ADDRESS_I == 8'h14 |-> ##3 !CHANNEL_OUTPUT_PIN_O[0])
        else $error("pin high after compare low write");
    cover property (WATCHDOG_RESET_O);
    cover property ($rose(CHANNEL_OUTPUT_PIN_O[0]));
    cover property (acc && ADDRESS_I == `CA_OFF_MODE);
endmodule : counter_array_checker

bind counter_array_pwm16_watchdog counter_array_checker #(.CHANNELS(CHANNELS)) chk (
    .CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .ADDRESS_I(ADDRESS_I), .READ_I(READ_I),
    .WRITE_I(WRITE_I), .WRITEDATA_I(WRITEDATA_I), .BYTEENABLE_I(BYTEENABLE_I),
    .READDATA_O(READDATA_O), .WAITREQUEST_O(WAITREQUEST_O),
    .CHANNEL_OUTPUT_PIN_O(CHANNEL_OUTPUT_PIN_O), .WATCHDOG_RESET_O(WATCHDOG_RESET_O));

// ### tb/sys_reset_model.sv
// model of the system reset logic and of a load on channel 0's pin
// assumes one clock; the reset request is a one-cycle pulse
`timescale 1ns/1ps
module sys_reset_model (
    input wire logic clk_i, // system clock
    input wire logic pulse_i, // watchdog reset request
    input wire logic pin_i, // channel 0 output
    output logic rst_o, // stretched system reset
    output int pulse_cnt, // requests seen
    output int high_len // last high time in clocks
);
    int hold = 0;
    int run = 0;
    initial rst_o = 1'b0;
    initial pulse_cnt = 0;
    initial high_len = 0;
    // stretch each request to four cycles, as a real reset tree would
    always @(posedge clk_i) begin
        if (pulse_i) begin
            pulse_cnt++;
            hold = 4;
        end
        rst_o <= (hold > 0);
        if (hold > 0) hold--;
        // high time of the last pulse, taken at its falling edge
        if (pin_i) run++;
        else begin
            if (run > 0) high_len = run;
            run = 0;
        end
    end
endmodule : sys_reset_model

// ### tb/testbench.sv
// self-checking bench: pulse-width channels and watchdog of the counter array
// assumes the design files, the checker and the reset model are compiled before it
`timescale 1ns/1ps
`include "counter_array_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module testbench;
    logic clk = 1'b0, tb_rst = 1'b1, rd = 1'b0, wr = 1'b0, idle = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata, q, q2;
    logic wait_o, wdr, mrst;
    logic [2:0] pins;
    int error_cnt = 0, compares = 0, pulses, hi_len, t, p;
    always #10 clk = ~clk;
    counter_array_pwm16_watchdog uut (.CLK_SYS_I(clk), .RESET_I(tb_rst | mrst),
        .ADDRESS_I(addr), .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wdata),
        .BYTEENABLE_I(4'hF), .READDATA_O(rdata), .WAITREQUEST_O(wait_o), .IDLE_I(idle),
        .EXT_TICK_I(1'b0), .CHANNEL_OUTPUT_PIN_O(pins), .WATCHDOG_RESET_O(wdr));
    sys_reset_model model (.clk_i(clk), .pulse_i(wdr), .pin_i(pins[0]), .rst_o(mrst),
        .pulse_cnt(pulses), .high_len(hi_len));
    // ****************
    // shared tasks
    // ****************
    task final_report;
        $display("%0d compares, %0d errors", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // one bus cycle; request held until a rising edge samples waitrequest low,
    // read data taken at that same edge, release only after it
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a; wdata <= {24'h000000, d}; wr <= w; rd <= !w;
        do begin @(posedge clk); n++; end while (wait_o !== 1'b0 && n < 20);
        if (n >= 20) begin error_cnt++; $display("[ERR] waitrequest expected 0 seen 1"); final_report(); end
        q = rdata;
        wr <= 1'b0; rd <= 1'b0;
    endtask : bus
    // bounded wait for the reset pulse, then let the stretched reset pass
    task automatic wait_pulse(input int lim);
        t = 0;
        do begin @(negedge clk); t++; end while (wdr !== 1'b1 && t < lim);
        if (t >= lim) begin error_cnt++; $display("[ERR] pulse expected 1 seen 0"); final_report(); end
        repeat (8) @(posedge clk);
    endtask : wait_pulse
    task automatic pin_for(input logic v);
        repeat (40) begin @(negedge clk); `CHK("pin0", v, pins[0]) end
    endtask : pin_for
    task automatic wait_pin(input logic v);
        t = 0;
        do begin @(negedge clk); t++; end while (pins[0] !== v && t < 100);
        `CHK("pin0 edge", v, pins[0])
    endtask : wait_pin
    // ****************
    // scenarios
    // ****************
    task t_defaults;
        bus(0, `CA_OFF_MODE, 8'h00); `CHK("mode", 32'h00000040, q)
        bus(0, 8'hFC, 8'h00); `CHK("unmapped", 32'h00000000, q)
        bus(0, `CA_OFF_CTRL, 8'h00); `CHK("run bit", 1'b0, q[6])
        wait_pulse(4000); `CHK("default timeout", 1'b1, t > 3040 && t < 3090)
        $display("defaults done");
    endtask : t_defaults
    task t_pwm16;
        bus(1, `CA_OFF_MODE, 8'h00); bus(1, `CA_OFF_MODE, 8'h08);
        bus(1, `CA_OFF_CNT_LO, 8'hF0); bus(1, `CA_OFF_CNT_HI, 8'hFF);
        bus(1, 8'h10, 8'hCA); bus(1, 8'h20, 8'h4A);
        bus(1, 8'h14, 8'hFE); bus(1, 8'h18, 8'hFF); bus(1, `CA_OFF_CTRL, 8'h40);
        wait_pin(1'b1); `CHK("pin1", 1'b0, pins[1])
        wait_pin(1'b0); @(posedge clk); @(negedge clk);
        `CHK("high time", 2, hi_len)
        bus(0, `CA_OFF_CTRL, 8'h00); `CHK("ctrl flags", 32'h000000C3, q)
        bus(1, `CA_OFF_CTRL, 8'h40); bus(0, `CA_OFF_CTRL, 8'h00);
        `CHK("flags cleared", 32'h00000040, q)
        bus(1, 8'h14, 8'h00); bus(1, 8'h18, 8'h00);
        bus(1, `CA_OFF_CNT_LO, 8'hF0); bus(1, `CA_OFF_CNT_HI, 8'hFF);
        wait_pin(1'b1);
        bus(1, `CA_OFF_CNT_LO, 8'hF0); bus(1, `CA_OFF_CNT_HI, 8'hFF); pin_for(1'b1);
        bus(1, 8'h14, 8'h00);
        bus(1, `CA_OFF_CNT_LO, 8'hF0); bus(1, `CA_OFF_CNT_HI, 8'hFF); pin_for(1'b0);
        $display("pwm16 done");
    endtask : t_pwm16
    task t_idle;
        bus(1, `CA_OFF_MODE, 8'h88);
        @(posedge clk); idle <= 1'b1;
        bus(0, `CA_OFF_CNT_LO, 8'h00); q2 = q; bus(0, `CA_OFF_CNT_LO, 8'h00);
        `CHK("count halted", q2, q)
        @(posedge clk); idle <= 1'b0;
        bus(0, `CA_OFF_CNT_LO, 8'h00); q2 = q; bus(0, `CA_OFF_CNT_LO, 8'h00);
        `CHK("count runs", 1'b1, q !== q2)
        $display("idle done");
    endtask : t_idle
    task t_watchdog;
        bus(1, 8'h34, 8'h01); bus(1, `CA_OFF_MODE, 8'h48);
        bus(1, `CA_OFF_MODE, 8'hC0); bus(0, `CA_OFF_MODE, 8'h00);
        `CHK("mode frozen", 32'h00000048, q)
        bus(1, `CA_OFF_CTRL, 8'h00); bus(0, `CA_OFF_CTRL, 8'h00);
        `CHK("run reads", 1'b0, q[6])
        bus(0, `CA_OFF_CNT_LO, 8'h00); q2 = q; bus(0, `CA_OFF_CNT_LO, 8'h00);
        `CHK("count forced on", 1'b1, q !== q2)
        bus(1, `CA_OFF_CNT_HI, 8'h12); bus(0, `CA_OFF_CNT_HI, 8'h00);
        `CHK("count write", 1'b1, q[7:0] !== 8'h12)
        bus(1, 8'h30, 8'hCA);
        do bus(0, `CA_OFF_CNT_LO, 8'h00); while (q[7:0] > 8'hF0);
        bus(1, 8'h38, 8'h00); p = 512 - q[7:0]; wait_pulse(700);
        `CHK("wd timeout", 1'b1, t > p - 10 && t < p + 4)
        $display("watchdog done");
    endtask : t_watchdog
    task t_force;
        bus(1, `CA_OFF_CTRL, 8'h04); wait_pulse(10);
        bus(1, `CA_OFF_MODE, 8'h00); p = pulses;
        bus(1, `CA_OFF_CTRL, 8'h04); repeat (10) @(posedge clk);
        `CHK("no pulse when off", p, pulses)
        bus(1, `CA_OFF_MODE, 8'h20); bus(1, `CA_OFF_MODE, 8'h00);
        bus(1, `CA_OFF_CTRL, 8'h04); wait_pulse(10);
        $display("force done");
    endtask : t_force
    initial begin
        repeat (6) @(posedge clk);
        tb_rst <= 1'b0;
        t_defaults; t_pwm16; t_idle; t_watchdog; t_force;
        final_report();
    end
endmodule : testbench
